/* rtl/tpc_defs.vh */
// Behaviour
// - Each channel owns one pin, handed to general-purpose port logic when unclaimed.
// - Small package: channel one has no pin but still works internally as compare.
// - Route option set: channel 0 captures comparator output; its pin is never driven.
// - Clock source select both bits set: counter steps on external clock pin.
// - External clock pin also feeds the modulo timer at the same time.
// - Any write to either counter byte clears counter and prescaler.
// - In debug mode, counter byte reads return the live frozen counter.
// - In debug mode, status or counter writes clear the counter read latch.
// - In debug mode, channel value reads return the real register content.
// - In debug mode, a channel status write clears that channel's read latch.
// - Input capture mode ignores software writes to the channel value.
// - Output compare: buffered value loads on next counter step after both bytes.
// - Edge PWM: buffered value loads when counter steps from top minus one to top.
`ifndef TPC_DEFS_VH
`define TPC_DEFS_VH

// Register offsets
`define TPC_OFS_SC        4'h0
`define TPC_OFS_CNTH      4'h1
`define TPC_OFS_CNTL      4'h2
`define TPC_OFS_MODH      4'h3
`define TPC_OFS_MODL      4'h4
`define TPC_OFS_CH_BASE   4'h5
`define TPC_OFS_CH_STRIDE 4'h3
`define TPC_OFS_CH_SC     4'h0
`define TPC_OFS_CH_VH     4'h1
`define TPC_OFS_CH_VL     4'h2
`define TPC_OFS_OPT       4'hb

// Timer status/control fields
`define TPC_SC_TOF        7
`define TPC_SC_CLKS_HI    4
`define TPC_SC_CLKS_LO    3
`define TPC_SC_PS_HI      2
`define TPC_SC_PS_LO      0
`define TPC_SC_WMASK      8'h7f

// Clock source encodings
`define TPC_CLK_NONE      2'h0
`define TPC_CLK_BUS       2'h1
`define TPC_CLK_FIXED     2'h2
`define TPC_CLK_EXT       2'h3

// Channel status/control fields
`define TPC_CH_F          7
`define TPC_CH_MS_HI      5
`define TPC_CH_MS_LO      4
`define TPC_CH_ELS_HI     3
`define TPC_CH_ELS_LO     2
`define TPC_CH_WMASK      8'h7f
`define TPC_MS_IC         2'h0
`define TPC_MS_OC         2'h1
`define TPC_ELS_OFF       2'h0
`define TPC_ELS_TOGGLE    2'h1
`define TPC_ELS_CLEAR     2'h2
`define TPC_ELS_SET       2'h3

// Option register fields
`define TPC_OPT_ROUTE     0

// Reset values and counter limits
`define TPC_BYTE_ZERO     8'h00
`define TPC_WORD_ZERO     16'h0000
`define TPC_WORD_ONE      16'h0001
`define TPC_FREE_TOP      16'hffff
`define TPC_PS_ZERO       7'h00
`define TPC_PS_ONE        7'h01
`define TPC_PS_ALL        7'h7f

`endif

/* rtl/tpc_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.vh"

module tpc_timer #(
    parameter NCH      = 2,
    parameter NOPIN_CH = 1
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [3:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    input  wire             bdm_active,
    input  wire             fixed_clk_tick,
    input  wire             small_package,
    input  wire             external_timer_clock_pin,
    input  wire             analog_comparator_out,
    input  wire [NCH-1:0]   pin_in,
    input  wire [NCH-1:0]   gpio_out,
    input  wire [NCH-1:0]   gpio_oe_n,
    output wire [NCH-1:0]   pin_out,
    output wire [NCH-1:0]   pin_oe_n,
    output reg              timer_external_clock_tick,
    output reg              route_active
);

    reg  [7:0]       sc_reg;
    reg  [15:0]      cnt_reg;
    reg  [15:0]      mod_reg;
    reg  [6:0]       ps_cnt_reg;
    reg              ext_prev_reg;
    reg              clat_v_reg;
    reg  [15:0]      clat_reg;
    reg  [7:0]       rd_next;
    reg              src_tick;
    wire [1:0]       clks;
    wire [2:0]       ps;
    wire [6:0]       ps_mask;
    wire             ps_done;
    wire             ext_rise;
    wire             cnt_step;
    wire [15:0]      top;
    wire [15:0]      top_m1;
    wire             wrap;
    wire             cnt_wr;
    wire             cnt_rd;
    wire [15:0]      cnt_view;
    wire [8*NCH-1:0] ch_rd_flat;

    assign clks    = sc_reg[`TPC_SC_CLKS_HI:`TPC_SC_CLKS_LO];
    assign ps      = sc_reg[`TPC_SC_PS_HI:`TPC_SC_PS_LO];
    assign ps_mask = ~(`TPC_PS_ALL << ps);
    assign ps_done = (ps_cnt_reg | ~ps_mask) == `TPC_PS_ALL;
    assign ext_rise = external_timer_clock_pin & ~ext_prev_reg;
    // Modulo of zero means the counter runs free to the full width
    assign top     = (mod_reg == `TPC_WORD_ZERO) ? `TPC_FREE_TOP : mod_reg;
    assign top_m1  = top - `TPC_WORD_ONE;
    assign wrap    = cnt_reg == top;
    // Counter frozen while debugging
    assign cnt_step = src_tick & ps_done & ~bdm_active;
    assign cnt_wr  = reg_wr & ((reg_addr == `TPC_OFS_CNTH) | (reg_addr == `TPC_OFS_CNTL));
    assign cnt_rd  = reg_rd & ((reg_addr == `TPC_OFS_CNTH) | (reg_addr == `TPC_OFS_CNTL));
    assign cnt_view = (clat_v_reg & ~bdm_active) ? clat_reg : cnt_reg;

    always @* begin
        case (clks)
            `TPC_CLK_BUS:   src_tick = 1'b1;
            `TPC_CLK_FIXED: src_tick = fixed_clk_tick;
            `TPC_CLK_EXT:   src_tick = ext_rise;
            default:        src_tick = 1'b0;
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            sc_reg       <= `TPC_BYTE_ZERO;
            cnt_reg      <= `TPC_WORD_ZERO;
            mod_reg      <= `TPC_WORD_ZERO;
            ps_cnt_reg   <= `TPC_PS_ZERO;
            ext_prev_reg <= 1'b0;
            route_active <= 1'b0;
            timer_external_clock_tick <= 1'b0;
        end else begin
            ext_prev_reg <= external_timer_clock_pin;
            timer_external_clock_tick <= ext_rise;
            if (cnt_wr) begin
                cnt_reg    <= `TPC_WORD_ZERO;
                ps_cnt_reg <= `TPC_PS_ZERO;
            end else begin
                if (src_tick & ~bdm_active)
                    ps_cnt_reg <= ps_done ? `TPC_PS_ZERO : ps_cnt_reg + `TPC_PS_ONE;
                if (cnt_step)
                    cnt_reg <= wrap ? `TPC_WORD_ZERO : cnt_reg + `TPC_WORD_ONE;
            end
            if (reg_wr & (reg_addr == `TPC_OFS_SC))
                sc_reg <= (reg_wdata & `TPC_SC_WMASK) | {sc_reg[`TPC_SC_TOF] & reg_wdata[`TPC_SC_TOF], 7'h00};
            // Overflow set wins over a clearing write
            if (cnt_step & wrap & ~cnt_wr)
                sc_reg[`TPC_SC_TOF] <= 1'b1;
            if (reg_wr & (reg_addr == `TPC_OFS_MODH))
                mod_reg[15:8] <= reg_wdata;
            if (reg_wr & (reg_addr == `TPC_OFS_MODL))
                mod_reg[7:0] <= reg_wdata;
            if (reg_wr & (reg_addr == `TPC_OFS_OPT))
                route_active <= reg_wdata[`TPC_OPT_ROUTE];
        end
    end

    // Two-byte read coherency for the counter
    always @(posedge core_clk) begin
        if (rst) begin
            clat_v_reg <= 1'b0;
            clat_reg   <= `TPC_WORD_ZERO;
        end else if (bdm_active) begin
            if (reg_wr & ((reg_addr == `TPC_OFS_SC) | cnt_wr))
                clat_v_reg <= 1'b0;
        end else if (cnt_rd) begin
            clat_v_reg <= ~clat_v_reg;
            if (~clat_v_reg)
                clat_reg <= cnt_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            localparam [31:0] CB = `TPC_OFS_CH_BASE + `TPC_OFS_CH_STRIDE * gi;
            localparam [3:0] A_SC = CB[3:0] + `TPC_OFS_CH_SC;
            localparam [3:0] A_VH = CB[3:0] + `TPC_OFS_CH_VH;
            localparam [3:0] A_VL = CB[3:0] + `TPC_OFS_CH_VL;
            reg  [7:0]  chsc_reg;
            reg  [15:0] cval_reg;
            reg  [15:0] wbuf_reg;
            reg         whi_reg;
            reg         wlo_reg;
            reg         rlat_v_reg;
            reg  [15:0] rlat_reg;
            reg         cap_prev_reg;
            reg         out_reg;
            reg         pout_reg;
            reg         poe_n_reg;
            reg  [7:0]  rd_byte;
            wire [1:0]  ms      = chsc_reg[`TPC_CH_MS_HI:`TPC_CH_MS_LO];
            wire [1:0]  els     = chsc_reg[`TPC_CH_ELS_HI:`TPC_CH_ELS_LO];
            wire        is_ic   = ms == `TPC_MS_IC;
            wire        is_oc   = ms == `TPC_MS_OC;
            wire        is_pwm  = ms[1];
            wire        routed  = (gi == 0) & route_active;
            wire        bonded  = ~(small_package & (gi == NOPIN_CH));
            wire        cap_src = routed ? analog_comparator_out : (bonded & pin_in[gi]);
            wire        rise    = cap_src & ~cap_prev_reg;
            wire        fall    = ~cap_src & cap_prev_reg;
            wire        cap_ev  = is_ic & ((els[0] & rise) | (els[1] & fall));
            wire        cnt_nxt_hit = cnt_step & ((wrap ? `TPC_WORD_ZERO : cnt_reg + `TPC_WORD_ONE) == cval_reg);
            wire        oc_ev   = is_oc & cnt_nxt_hit;
            wire        pend    = whi_reg & wlo_reg;
            wire        load    = pend & ((clks == `TPC_CLK_NONE) | (is_oc & cnt_step) |
                                          (is_pwm & cnt_step & (cnt_reg == top_m1)));
            wire        sc_wr   = reg_wr & (reg_addr == A_SC);
            wire        v_rd    = reg_rd & ((reg_addr == A_VH) | (reg_addr == A_VL));
            wire        claim   = ~is_ic & (els != `TPC_ELS_OFF) & ~routed;
            wire [15:0] v_view  = (rlat_v_reg & ~bdm_active) ? rlat_reg : cval_reg;

            always @* begin
                rd_byte = `TPC_BYTE_ZERO;
                if (reg_addr == A_SC)
                    rd_byte = chsc_reg;
                else if (reg_addr == A_VH)
                    rd_byte = v_view[15:8];
                else if (reg_addr == A_VL)
                    rd_byte = v_view[7:0];
            end
            assign ch_rd_flat[8*gi +: 8] = rd_byte;

            always @(posedge core_clk) begin
                if (rst) begin
                    chsc_reg     <= `TPC_BYTE_ZERO;
                    cval_reg     <= `TPC_WORD_ZERO;
                    wbuf_reg     <= `TPC_WORD_ZERO;
                    whi_reg      <= 1'b0;
                    wlo_reg      <= 1'b0;
                    cap_prev_reg <= 1'b0;
                    out_reg      <= 1'b0;
                end else begin
                    cap_prev_reg <= cap_src;
                    if (sc_wr)
                        chsc_reg <= (reg_wdata & `TPC_CH_WMASK) |
                                    {chsc_reg[`TPC_CH_F] & reg_wdata[`TPC_CH_F], 7'h00};
                    // Event flag set wins over clear
                    if (cap_ev | oc_ev)
                        chsc_reg[`TPC_CH_F] <= 1'b1;
                    if (load) begin
                        cval_reg <= wbuf_reg;
                        whi_reg  <= 1'b0;
                        wlo_reg  <= 1'b0;
                    end
                    if (is_ic) begin
                        whi_reg <= 1'b0;
                        wlo_reg <= 1'b0;
                        if (cap_ev)
                            cval_reg <= cnt_reg;
                    end else begin
                        if (reg_wr & (reg_addr == A_VH)) begin
                            wbuf_reg[15:8] <= reg_wdata;
                            whi_reg        <= 1'b1;
                        end
                        if (reg_wr & (reg_addr == A_VL)) begin
                            wbuf_reg[7:0] <= reg_wdata;
                            wlo_reg       <= 1'b1;
                        end
                    end
                    if (oc_ev) begin
                        case (els)
                            `TPC_ELS_TOGGLE: out_reg <= ~out_reg;
                            `TPC_ELS_CLEAR:  out_reg <= 1'b0;
                            `TPC_ELS_SET:    out_reg <= 1'b1;
                            default:         out_reg <= out_reg;
                        endcase
                    end else if (is_pwm) begin
                        // High-true when upper edge bit set
                        out_reg <= els[1] ~^ (cnt_reg < cval_reg);
                    end
                end
            end

            // Channel read coherency latch
            always @(posedge core_clk) begin
                if (rst) begin
                    rlat_v_reg <= 1'b0;
                    rlat_reg   <= `TPC_WORD_ZERO;
                end else if (bdm_active) begin
                    if (sc_wr)
                        rlat_v_reg <= 1'b0;
                end else if (v_rd) begin
                    rlat_v_reg <= ~rlat_v_reg;
                    if (~rlat_v_reg)
                        rlat_reg <= cval_reg;
                end
            end

            always @(posedge core_clk) begin
                if (rst) begin
                    pout_reg  <= 1'b0;
                    poe_n_reg <= 1'b1;
                end else begin
                    pout_reg  <= claim ? out_reg : gpio_out[gi];
                    // Unbonded or routed pin is never driven
                    poe_n_reg <= (~bonded | routed) ? 1'b1 : (claim ? 1'b0 : gpio_oe_n[gi]);
                end
            end
            assign pin_out[gi]  = pout_reg;
            assign pin_oe_n[gi] = poe_n_reg;
        end
    endgenerate

    integer k;
    always @* begin
        rd_next = `TPC_BYTE_ZERO;
        case (reg_addr)
            `TPC_OFS_SC:   rd_next = sc_reg;
            `TPC_OFS_CNTH: rd_next = cnt_view[15:8];
            `TPC_OFS_CNTL: rd_next = cnt_view[7:0];
            `TPC_OFS_MODH: rd_next = mod_reg[15:8];
            `TPC_OFS_MODL: rd_next = mod_reg[7:0];
            `TPC_OFS_OPT:  rd_next = {7'h00, route_active};
            default: begin
                for (k = 0; k < NCH; k = k + 1)
                    rd_next = rd_next | ch_rd_flat[8*k +: 8];
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst)
            reg_rdata <= `TPC_BYTE_ZERO;
        else if (reg_rd)
            reg_rdata <= rd_next;
        else
            reg_rdata <= `TPC_BYTE_ZERO;
    end

endmodule // tpc_timer
`default_nettype wire

/* testbench/test_timer_pwm_counter_coherency.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.vh"
module test_timer_pwm_counter_coherency;
    logic        core_clk, rst, reg_wr, reg_rd, background_debug_mode, fck, small_pkg, ext_pin, analog_comparator;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, d;
    logic [1:0]  pin_in, gpio_out, gpio_oe_n;
    wire  [7:0]  reg_rdata;
    wire  [1:0]  pin_out, pin_oe_n;
    wire         ext_tick, route_active;
    logic [15:0] v, w, x;
    integer      seed, failures, checks, k;
    localparam [3:0] C0 = `TPC_OFS_CH_BASE;
    localparam [3:0] C1 = `TPC_OFS_CH_BASE + `TPC_OFS_CH_STRIDE;

    tpc_timer #(.NCH(2), .NOPIN_CH(1)) uut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bdm_active(background_debug_mode), .fixed_clk_tick(fck),
        .small_package(small_pkg), .external_timer_clock_pin(ext_pin), .analog_comparator_out(analog_comparator),
        .pin_in(pin_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .timer_external_clock_tick(ext_tick), .route_active(route_active));

    function automatic [7:0] tsc(input [1:0] c);
        tsc = {6'h00, c} << `TPC_SC_CLKS_LO;
    endfunction
    function automatic [7:0] csc(input [1:0] ms, input [1:0] els);
        csc = ({6'h00, ms} << `TPC_CH_MS_LO) | ({6'h00, els} << `TPC_CH_ELS_LO);
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks = checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // Strobe left high so back-to-back writes need no gap
    task automatic wr(input logic [3:0] a, input logic [7:0] dt);
        reg_addr <= a; reg_wdata <= dt; reg_wr <= 1'b1; reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] dt);
        reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        dt = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] dt);
        rd(a, dt[15:8]);
        rd(a + 4'h1, dt[7:0]);
    endtask
    task automatic step(input integer n, input logic t);
        reg_wr <= 1'b0; reg_rd <= 1'b0;
        repeat (n) begin
            fck <= t;
            @(posedge core_clk);
            fck <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #60000;
        failures = failures + 1;
        results;
    end
    initial begin
        seed = 32'hd5b5c750; failures = 0; checks = 0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 4'h0; reg_wdata = 8'h00; background_debug_mode = 1'b0; fck = 1'b0; small_pkg = 1'b0; ext_pin = 1'b0;
        analog_comparator = 1'b0; pin_in = 2'h0; gpio_out = 2'h0; gpio_oe_n = 2'h3;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_EXT));
        wr(`TPC_OFS_CNTH, 8'h00);
        k = 2 + {$random(seed)} % 8;
        repeat (k) begin
            step(1, 1'b0);
            ext_pin <= 1'b1;
            step(1, 1'b0);
            ext_pin <= 1'b0;
        end
        step(1, 1'b0);
        rd16(`TPC_OFS_CNTH, v);
        chk("ext_count", k[15:0], v);
        wr(`TPC_OFS_CNTL, $random(seed));
        rd16(`TPC_OFS_CNTH, v);
        chk("cnt_clear", 16'h0000, v);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_FIXED));
        wr(C0, csc(`TPC_MS_OC, `TPC_ELS_OFF));
        w = $random(seed);
        wr(C0 + 4'h1, w[15:8]);
        wr(C0 + 4'h2, w[7:0]);
        rd16(C0 + 4'h1, v);
        chk("oc_hold", 16'h0000, v);
        step(1, 1'b1);
        rd16(C0 + 4'h1, v);
        chk("oc_load", w, v);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_NONE));
        wr(`TPC_OFS_CNTH, 8'h00);
        wr(`TPC_OFS_MODL, 8'h05);
        wr(C0, csc(2'h2, `TPC_ELS_CLEAR));
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_FIXED));
        x = $random(seed);
        wr(C0 + 4'h1, x[15:8]);
        wr(C0 + 4'h2, x[7:0]);
        step(4, 1'b1);
        rd16(C0 + 4'h1, v);
        chk("pwm_hold", w, v);
        step(1, 1'b1);
        rd16(C0 + 4'h1, v);
        chk("pwm_load", x, v);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_NONE));
        wr(C0, csc(`TPC_MS_IC, `TPC_ELS_TOGGLE));
        wr(C0 + 4'h1, $random(seed));
        wr(C0 + 4'h2, $random(seed));
        step(1, 1'b0);
        rd16(C0 + 4'h1, v);
        chk("ic_lock", x, v);
        wr(`TPC_OFS_MODL, 8'h00);
        wr(`TPC_OFS_CNTH, 8'h00);
        wr(`TPC_OFS_OPT, 8'h01);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_FIXED));
        k = 1 + {$random(seed)} % 6;
        step(k, 1'b1);
        pin_in <= 2'h1;
        step(2, 1'b1);
        analog_comparator <= 1'b1;
        step(2, 1'b0);
        rd16(C0 + 4'h1, v);
        chk("route_cap", k[15:0] + 16'h0002, v);
        chk("route_flag", 16'h0001, {15'h0000, route_active});
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_NONE));
        wr(C1, csc(`TPC_MS_OC, `TPC_ELS_OFF));
        w = $random(seed);
        wr(C1 + 4'h1, w[15:8]);
        wr(C1 + 4'h2, w[7:0]);
        step(1, 1'b0);
        rd(C1 + 4'h1, d);
        x = $random(seed);
        wr(C1 + 4'h1, x[15:8]);
        wr(C1 + 4'h2, x[7:0]);
        step(1, 1'b0);
        background_debug_mode <= 1'b1;
        rd(C1 + 4'h2, d);
        chk("dbg_chan", {8'h00, x[7:0]}, {8'h00, d});
        wr(C1, csc(`TPC_MS_OC, `TPC_ELS_OFF));
        background_debug_mode <= 1'b0;
        rd16(C1 + 4'h1, v);
        chk("dbg_chan_clr", x, v);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_FIXED));
        wr(`TPC_OFS_CNTH, 8'h00);
        step(2 + {$random(seed)} % 6, 1'b1);
        rd(`TPC_OFS_CNTH, d);
        wr(`TPC_OFS_CNTH, 8'h00);
        background_debug_mode <= 1'b1;
        rd(`TPC_OFS_CNTL, d);
        chk("dbg_cnt", 16'h0000, {8'h00, d});
        rd(`TPC_OFS_CNTL, d);
        wr(`TPC_OFS_CNTL, 8'h00);
        rd(`TPC_OFS_CNTL, d);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_FIXED));
        background_debug_mode <= 1'b0;
        step(3, 1'b1);
        rd(`TPC_OFS_CNTL, d);
        chk("dbg_cnt_clr", 16'h0003, {8'h00, d});
        rd(`TPC_OFS_CNTH, d);
        wr(`TPC_OFS_OPT, 8'h00);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_NONE));
        wr(C1, csc(`TPC_MS_OC, `TPC_ELS_SET));
        wr(C1 + 4'h1, 8'h00);
        wr(C1 + 4'h2, 8'h03);
        wr(`TPC_OFS_CNTH, 8'h00);
        wr(`TPC_OFS_SC, tsc(`TPC_CLK_FIXED));
        gpio_out <= $random(seed);
        gpio_oe_n <= $random(seed);
        step(4, 1'b1);
        #1;
        chk("pin_claim", 16'h0000, {15'h0000, pin_oe_n[1]});
        chk("oc_pin", 16'h0001, {15'h0000, pin_out[1]});
        chk("gpio_oe", {15'h0000, gpio_oe_n[0]}, {15'h0000, pin_oe_n[0]});
        chk("gpio_out", {15'h0000, gpio_out[0]}, {15'h0000, pin_out[0]});
        small_pkg <= 1'b1;
        step(2, 1'b0);
        #1;
        chk("no_pin", 16'h0001, {15'h0000, pin_oe_n[1]});
        rd(C1, d);
        chk("no_pin_cmp", {8'h00, csc(`TPC_MS_OC, `TPC_ELS_SET) | 8'h80}, {8'h00, d});
        rd(4'hc, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        results;
    end
endmodule // test_timer_pwm_counter_coherency
`default_nettype wire

/* testbench/tpc_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tpc_defs.vh"
module tpc_timer_props #(
    parameter NCH      = 2,
    parameter NOPIN_CH = 1
) (
    input wire logic           core_clk,
    input wire logic           rst,
    input wire logic [3:0]     reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_rdata,
    input wire logic           bdm_active,
    input wire logic           small_package,
    input wire logic           external_timer_clock_pin,
    input wire logic [NCH-1:0] pin_oe_n,
    input wire logic           timer_external_clock_tick,
    input wire logic           route_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    reset_state_a: assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00 && !route_active)
        else $error("outputs not cleared by reset");
    read_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    unmapped_read_a: assert property (reg_rd && reg_addr > `TPC_OFS_OPT |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    route_follow_a: assert property (reg_wr && reg_addr == `TPC_OFS_OPT |=> route_active == $past(reg_wdata[0]))
        else $error("route flag not written");
    route_pin_a: assert property (route_active [*2] |-> pin_oe_n[0])
        else $error("routed channel pin still driven");
    unbonded_pin_a: assert property (small_package && $past(small_package) && $past(small_package, 2)
        |-> pin_oe_n[NOPIN_CH])
        else $error("unbonded channel pin driven");
    ext_tick_a: assert property ($rose(external_timer_clock_pin) |=> timer_external_clock_tick)
        else $error("external clock edge not passed on");
    tick_cause_a: assert property (timer_external_clock_tick
        |-> $past(external_timer_clock_pin) && !$past(external_timer_clock_pin, 2))
        else $error("external tick without edge");
    dbg_clear_a: assert property (bdm_active && reg_wr
        && (reg_addr == `TPC_OFS_CNTH || reg_addr == `TPC_OFS_CNTL)
        ##1 bdm_active && reg_rd && reg_addr == `TPC_OFS_CNTL |=> reg_rdata == 8'h00)
        else $error("counter not zero after write");
    dbg_frozen_a: assert property (bdm_active && reg_rd && reg_addr == `TPC_OFS_CNTL
        ##1 bdm_active && !reg_wr
        ##1 bdm_active && reg_rd && reg_addr == `TPC_OFS_CNTL |=> reg_rdata == $past(reg_rdata, 2))
        else $error("debug counter read not frozen");

    ext_seen_c: cover property (timer_external_clock_tick);
    route_seen_c: cover property (route_active [*2]);
    dbg_read_c: cover property (bdm_active && reg_rd);
endmodule // tpc_timer_props

bind tpc_timer tpc_timer_props #(.NCH(NCH), .NOPIN_CH(NOPIN_CH)) props_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bdm_active(bdm_active), .small_package(small_package),
    .external_timer_clock_pin(external_timer_clock_pin), .pin_oe_n(pin_oe_n),
    .timer_external_clock_tick(timer_external_clock_tick), .route_active(route_active));
`default_nettype wire
